// ===== design/fsio_core.sv
// Purpose: fp state register, unimplemented-instruction traps, asr decode, window regs
// Assumes: one request per cycle from the decoder; answer one cycle later
// Notes: other architected asrs live elsewhere; this block only polices them
`timescale 1ns/1ps
`include "fsio_defs.svh"

module fsio_core import fsio_pkg::*; (
	input wire logic clock, // 250 MHz core clock
	input wire logic rst_n, // async reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire fsio_req_t req, // decoded instruction request
	input wire logic rf_we, // integer register write strobe
	input wire logic [4:0] rf_widx, // architectural write register number
	input wire logic [`FSIO_XLEN-1:0] rf_wdata, // write data
	input wire logic [4:0] rf_ridx, // architectural read register number
	input wire logic [`FSIO_CWP_W-1:0] cwp, // current window pointer
	input wire logic [`FSIO_GL_W-1:0] gl, // current global level
	output logic rsp_valid_q, // answer strobe, one cycle
	output fsio_rsp_t rsp_q, // trap flag, type and read data
	output logic [`FSIO_XLEN-1:0] rf_rdata_q, // registered read data
	output logic [`FSIO_XLEN-1:0] fsr_q // live view of the fp state register
);

	logic [1:0] rd_q;
	logic [`FSIO_EXC_W-1:0] tem_q;
	logic [`FSIO_EXC_W-1:0] aexc_q;
	logic [`FSIO_EXC_W-1:0] cexc_q;
	logic [2:0] ftt_q;
	logic [1:0] rd_d;
	logic [`FSIO_EXC_W-1:0] tem_d;
	logic [`FSIO_EXC_W-1:0] aexc_d;
	logic [`FSIO_EXC_W-1:0] cexc_d;
	logic [2:0] ftt_d;
	logic [`FSIO_XLEN-1:0] fsr_d;
	fsio_rsp_t rsp_d;
	logic [`FSIO_XLEN-1:0] asr_q [`FSIO_ASR_SCRATCH];
	logic asr_we;
	logic [1:0] asr_sel;
	logic [`FSIO_XLEN-1:0] rf_q [`FSIO_RF_TOTAL];
	logic [7:0] rf_wslot;
	logic [7:0] rf_rslot;
	// literals cannot be bit-selected, so the masks live as typed constants
	localparam logic [3:0] asr_priv_mask = `FSIO_ASR_PRIV_MASK;
	localparam logic [31:0] asr_defined = `FSIO_ASR_DEFINED;

	// architectural register number to physical slot
	function automatic logic [7:0] rf_map(input logic [4:0] idx,
		input logic [`FSIO_CWP_W-1:0] w, input logic [`FSIO_GL_W-1:0] g);
		logic [`FSIO_CWP_W-1:0] wn;
		logic [`FSIO_GL_W-1:0] gc;
		logic [7:0] slot;
		// outs of a window are the ins of the next one; eight windows wrap freely
		wn = w + `FSIO_CWP_W'(1);
		gc = (g > `FSIO_MAXGL) ? `FSIO_MAXGL : g;
		unique case (idx[4:3])
			2'h0: slot = {3'h0, gc, idx[2:0]};
			2'h1: slot = `FSIO_GBASE + {1'b0, wn, 1'b1, idx[2:0]};
			2'h2: slot = `FSIO_GBASE + {1'b0, w, 1'b0, idx[2:0]};
			2'h3: slot = `FSIO_GBASE + {1'b0, w, 1'b1, idx[2:0]};
		endcase
		return slot;
	endfunction

	// ieee exception set of one operation, underflow formed here
	function automatic logic [`FSIO_EXC_W-1:0] fp_flags(input logic [`FSIO_EXC_W-1:0] e,
		input logic tiny, input logic [`FSIO_EXC_W-1:0] tem);
		logic [`FSIO_EXC_W-1:0] f;
		f = e;
		// tiny judged before rounding; masked uf also needs inexact
		f[`FSIO_UF_BIT] = tiny & (tem[`FSIO_UF_BIT] | e[`FSIO_NX_BIT]);
		return f;
	endfunction

	function automatic logic [`FSIO_XLEN-1:0] fsr_view(input logic [1:0] rd,
		input logic [`FSIO_EXC_W-1:0] tem, input logic [2:0] ftt,
		input logic [`FSIO_EXC_W-1:0] aexc, input logic [`FSIO_EXC_W-1:0] cexc);
		logic [`FSIO_XLEN-1:0] v;
		v = '0;
		v[`FSIO_RD_LO +: 2] = rd;
		v[`FSIO_TEM_LO +: `FSIO_EXC_W] = tem;
		v[`FSIO_NS_BIT] = 1'b0;
		v[`FSIO_VER_LO +: 3] = `FSIO_VER_VAL;
		v[`FSIO_FTT_LO +: 3] = ftt;
		v[`FSIO_AEXC_LO +: `FSIO_EXC_W] = aexc;
		v[`FSIO_CEXC_LO +: `FSIO_EXC_W] = cexc;
		return v;
	endfunction

	assign asr_sel = req.num[1:0];
	assign rf_wslot = rf_map(rf_widx, cwp, gl);
	assign rf_rslot = rf_map(rf_ridx, cwp, gl);

	always_comb begin
		logic [`FSIO_EXC_W-1:0] fl;
		logic impl_asr;
		fl = fp_flags(req.fexc, req.ftiny, tem_q);
		impl_asr = (req.num >= `FSIO_ASR_IMPL_LO);
		rd_d = rd_q;
		tem_d = tem_q;
		aexc_d = aexc_q;
		cexc_d = cexc_q;
		ftt_d = ftt_q;
		rsp_d = '0;
		rsp_d.ttype = FSIO_T_NONE;
		asr_we = 1'b0;
		if (req.valid) begin
			unique case (req.kind)
				FSIO_K_FPOP: begin
					if (!req.impl) begin
						rsp_d.trap = 1'b1;
						rsp_d.ttype = FSIO_T_FP_MISC;
						ftt_d = `FSIO_FTT_MISSING;
					end else if (req.fincomplete) begin
						rsp_d.trap = 1'b1;
						rsp_d.ttype = FSIO_T_FP_MISC;
						ftt_d = `FSIO_FTT_INCOMPLETE;
					end else if ((fl & tem_q) != '0) begin
						// enabled exception traps, accrued left alone
						rsp_d.trap = 1'b1;
						rsp_d.ttype = FSIO_T_FP_IEEE;
						cexc_d = fl;
						ftt_d = `FSIO_FTT_IEEE;
					end else begin
						cexc_d = fl;
						aexc_d = aexc_q | fl;
						ftt_d = `FSIO_FTT_NONE;
					end
				end
				FSIO_K_LDFSR: begin
					// ns, ver and ftt are not written
					rd_d = req.wdata[`FSIO_RD_LO +: 2];
					tem_d = req.wdata[`FSIO_TEM_LO +: `FSIO_EXC_W];
					aexc_d = req.wdata[`FSIO_AEXC_LO +: `FSIO_EXC_W];
					cexc_d = req.wdata[`FSIO_CEXC_LO +: `FSIO_EXC_W];
				end
				FSIO_K_STFSR: begin
					rsp_d.data = fsr_view(rd_q, tem_q, ftt_q, aexc_q, cexc_q);
				end
				FSIO_K_RDASR, FSIO_K_WRASR: begin
					if (impl_asr) begin
						if (asr_priv_mask[asr_sel] && !req.priv) begin
							rsp_d.trap = 1'b1;
							rsp_d.ttype = FSIO_T_PRIV;
						end else if (req.kind == FSIO_K_WRASR) begin
							asr_we = 1'b1;
						end else begin
							rsp_d.data = asr_q[asr_sel];
						end
					end else if (!asr_defined[req.num]) begin
						rsp_d.trap = 1'b1;
						rsp_d.ttype = FSIO_T_ILLEGAL;
					end
				end
				FSIO_K_READ_PRIVILEGED_REGISTER_INSTR: begin
					if (req.num == `FSIO_FQ_PRNUM) begin
						rsp_d.trap = 1'b1;
						rsp_d.ttype = FSIO_T_ILLEGAL;
					end
				end
				FSIO_K_OTHER: begin
					if (!req.impl) begin
						rsp_d.trap = 1'b1;
						rsp_d.ttype = FSIO_T_ILLEGAL;
					end
				end
				default: begin
					rsp_d.trap = 1'b1;
					rsp_d.ttype = FSIO_T_ILLEGAL;
				end
			endcase
		end
		fsr_d = fsr_view(rd_d, tem_d, ftt_d, aexc_d, cexc_d);
	end

	// fp state; ftt only ever takes codes 0 to 3
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_q <= 2'h0;
			tem_q <= 5'h00;
			aexc_q <= 5'h00;
			cexc_q <= 5'h00;
			ftt_q <= `FSIO_FTT_NONE;
			fsr_q <= '0;
		end else if (ce) begin
			rd_q <= rd_d;
			tem_q <= tem_d;
			aexc_q <= aexc_d;
			cexc_q <= cexc_d;
			ftt_q <= ftt_d;
			fsr_q <= fsr_d;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_q <= 1'b0;
			rsp_q <= '0;
		end else if (ce) begin
			rsp_valid_q <= req.valid;
			rsp_q <= rsp_d;
		end
	end

	// scratch storage for asrs 28 to 31
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `FSIO_ASR_SCRATCH; i++) begin
				asr_q[i] <= '0;
			end
		end else if (ce && asr_we) begin
			asr_q[asr_sel] <= req.wdata;
		end
	end

	// windowed integer file; r0 stays zero
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < `FSIO_RF_TOTAL; i++) begin
				rf_q[i] <= '0;
			end
		end else if (ce && rf_we && (rf_widx != 5'h00)) begin
			rf_q[rf_wslot] <= rf_wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rf_rdata_q <= '0;
		end else if (ce) begin
			rf_rdata_q <= (rf_ridx == 5'h00) ? '0 : rf_q[rf_rslot];
		end
	end

endmodule

// ===== design/fsio_defs.svh
// Purpose: named constants of the fp state and instruction check block
// Assumes: included by the package and by the core
// Notes: definitions only
`ifndef FSIO_DEFS_SVH
`define FSIO_DEFS_SVH

`define FSIO_XLEN 64
// register file: 3 global sets of 8 plus 8 windows of 16 = 152 registers
`define FSIO_GSETS 3
`define FSIO_MAXGL 2'h2
`define FSIO_GSET_REGS 8
`define FSIO_NWIN 8
`define FSIO_WIN_REGS 16
`define FSIO_RF_TOTAL 152
`define FSIO_GBASE 8'h18
`define FSIO_CWP_W 3
`define FSIO_GL_W 2

// fp state register layout
`define FSIO_CEXC_LO 0
`define FSIO_AEXC_LO 5
`define FSIO_FTT_LO 14
`define FSIO_VER_LO 17
`define FSIO_NS_BIT 22
`define FSIO_TEM_LO 23
`define FSIO_RD_LO 30
`define FSIO_EXC_W 5
// version value is arbitrary
`define FSIO_VER_VAL 3'h0

// ieee exception bits inside a 5-bit group
`define FSIO_UF_BIT 2
`define FSIO_NX_BIT 0

// trap type field codes; code 4 is never produced
`define FSIO_FTT_NONE 3'h0
`define FSIO_FTT_IEEE 3'h1
`define FSIO_FTT_INCOMPLETE 3'h2
`define FSIO_FTT_MISSING 3'h3

// ancillary register numbers
`define FSIO_ASR_IMPL_LO 5'h1c
`define FSIO_ASR_DEFINED 32'h03f8007d
`define FSIO_ASR_PRIV_MASK 4'hc
`define FSIO_ASR_SCRATCH 4
// privileged register number of the deferred queue
`define FSIO_FQ_PRNUM 5'h0f

`endif

// ===== design/fsio_pkg.sv
// Purpose: types of the fp state and instruction check block
// Assumes: fsio_defs.svh holds the constants
// Notes: request and answer travel as packed structs
`include "fsio_defs.svh"

package fsio_pkg;

	typedef enum logic [2:0] {
		FSIO_K_OTHER = 3'h0,
		FSIO_K_FPOP = 3'h1,
		FSIO_K_RDASR = 3'h3,
		FSIO_K_WRASR = 3'h2,
		FSIO_K_READ_PRIVILEGED_REGISTER_INSTR = 3'h6,
		FSIO_K_LDFSR = 3'h7,
		FSIO_K_STFSR = 3'h5
	} fsio_kind_t;

	typedef enum logic [2:0] {
		FSIO_T_NONE = 3'h0,
		FSIO_T_ILLEGAL = 3'h1,
		FSIO_T_FP_MISC = 3'h3,
		FSIO_T_FP_IEEE = 3'h2,
		FSIO_T_PRIV = 3'h6
	} fsio_trap_t;

	typedef struct packed {
		logic valid;
		fsio_kind_t kind;
		logic priv;
		logic impl;
		logic [4:0] num;
		logic [`FSIO_XLEN-1:0] wdata;
		logic [`FSIO_EXC_W-1:0] fexc;
		logic ftiny;
		logic fincomplete;
	} fsio_req_t;

	typedef struct packed {
		logic trap;
		fsio_trap_t ttype;
		logic [`FSIO_XLEN-1:0] data;
	} fsio_rsp_t;

endpackage

// ===== sim/fsio_properties.sv
// Purpose: port-level checks of the fp state block
// Assumes: one clock domain, async active-low reset
// Notes: bound to fsio_core below
`timescale 1ns/1ps
`include "fsio_defs.svh"
module fsio_properties import fsio_pkg::*; (
	input wire logic clock, // core clock
	input wire logic rst_n, // reset, active low
	input wire logic ce, // clock enable
	input wire fsio_req_t req, // request
	input wire logic rf_we, // write strobe
	input wire logic [4:0] rf_widx, // write index
	input wire logic [63:0] rf_wdata, // write data
	input wire logic [4:0] rf_ridx, // read index
	input wire logic [2:0] cwp, // window pointer
	input wire logic [1:0] gl, // global level
	input wire logic rsp_valid_q, // answer strobe
	input wire fsio_rsp_t rsp_q, // answer
	input wire logic [63:0] rf_rdata_q, // read data
	input wire logic [63:0] fsr_q // fp state view
);
	logic [31:0] asr_def;
	logic [2:0] ftt;
	logic tk;
	assign asr_def = `FSIO_ASR_DEFINED;
	assign ftt = fsr_q[16:14];
	assign tk = ce && req.valid;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_answer_next: assert property (tk |=> rsp_valid_q)
		else $error("request not answered");
	a_other_unimpl: assert property (tk && req.kind == FSIO_K_OTHER && !req.impl
		|=> rsp_q.trap && rsp_q.ttype == FSIO_T_ILLEGAL) else $error("no illegal trap");
	a_fpop_missing: assert property (tk && req.kind == FSIO_K_FPOP && !req.impl
		|=> rsp_q.ttype == FSIO_T_FP_MISC && ftt == 3'h3) else $error("missing op code");
	a_fpop_incomplete: assert property (tk && req.kind == FSIO_K_FPOP && req.impl
		&& req.fincomplete |=> rsp_q.ttype == FSIO_T_FP_MISC && ftt == 3'h2)
		else $error("incomplete op code");
	a_ns_zero: assert property (!fsr_q[22]) else $error("ns bit set");
	a_ver_fixed: assert property (fsr_q[19:17] == `FSIO_VER_VAL)
		else $error("version changed");
	a_no_queue_code: assert property (ftt != 3'h4) else $error("trap type 4");
	a_queue_read: assert property (tk && req.kind == FSIO_K_READ_PRIVILEGED_REGISTER_INSTR && req.num == 5'h0f
		|=> rsp_q.ttype == FSIO_T_ILLEGAL) else $error("queue read not trapped");
	a_asr_reserved: assert property (tk && (req.kind == FSIO_K_RDASR
		|| req.kind == FSIO_K_WRASR) && req.num < 5'h1c && !asr_def[req.num]
		|=> rsp_q.ttype == FSIO_T_ILLEGAL) else $error("reserved asr passed");
	a_aexc_held: assert property (tk && req.kind == FSIO_K_FPOP && req.impl
		&& !req.fincomplete && (req.fexc & fsr_q[27:23] & 5'h1b) != 5'h0
		|=> rsp_q.ttype == FSIO_T_FP_IEEE && $stable(fsr_q[9:5])) else $error("aexc moved");
	a_r0_zero: assert property (ce && rf_ridx == 5'h0 |=> rf_rdata_q == 64'h0)
		else $error("r0 not zero");
endmodule
bind fsio_core fsio_properties chk (.clock(clock), .rst_n(rst_n), .ce(ce), .req(req),
	.rf_we(rf_we), .rf_widx(rf_widx), .rf_wdata(rf_wdata), .rf_ridx(rf_ridx), .cwp(cwp),
	.gl(gl), .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .rf_rdata_q(rf_rdata_q), .fsr_q(fsr_q));

// ===== sim/fsio_core_test.sv
// Purpose: self-checking bench of the fp state block
// Assumes: one answer a cycle after each taken request
// Notes: ce and gl move only in their own scenarios
`timescale 1ns/1ps
module fsio_core_test;
	import fsio_pkg::*;
	logic clock, rst_n, ce, rf_we, rsp_valid_q;
	fsio_req_t req;
	fsio_rsp_t rsp_q;
	logic [4:0] rf_widx, rf_ridx;
	logic [63:0] rf_wdata, rf_rdata_q, fsr_q;
	logic [2:0] cwp;
	logic [1:0] gl;
	int err_total, n_checks;
	fsio_core dut (.clock(clock), .rst_n(rst_n), .ce(ce), .req(req), .rf_we(rf_we),
		.rf_widx(rf_widx), .rf_wdata(rf_wdata), .rf_ridx(rf_ridx), .cwp(cwp), .gl(gl),
		.rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .rf_rdata_q(rf_rdata_q), .fsr_q(fsr_q));
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ip is {impl, priv}, f is {fexc, ftiny, fincomplete}
	function automatic fsio_req_t rq(input fsio_kind_t k, input logic [1:0] ip,
		input logic [4:0] n, input logic [63:0] w, input logic [6:0] f);
		rq = '{1'b1, k, ip[0], ip[1], n, w, f[6:2], f[1], f[0]};
	endfunction
	task automatic send(input fsio_req_t r, input fsio_trap_t t);
		@(posedge clock);
		req <= r;
		@(posedge clock);
		req.valid <= 1'b0;
		#1;
		chk(rsp_valid_q, 64'h1, "no answer");
		chk(rsp_q.trap, 64'(t != FSIO_T_NONE), "trap flag");
		chk(rsp_q.ttype, 64'(t), "trap type");
	endtask
	task automatic rf_cyc(input logic we, input logic [4:0] wi, input logic [4:0] ri,
		input logic [63:0] d, input logic [2:0] w);
		@(posedge clock);
		rf_we <= we;
		rf_widx <= wi;
		rf_ridx <= ri;
		rf_wdata <= d;
		cwp <= w;
		@(posedge clock);
		rf_we <= 1'b0;
		#1;
	endtask
	task t_fsr;
		send(rq(FSIO_K_LDFSR, 2'b00, 5'h0, 64'h804f0145, 7'h0), FSIO_T_NONE);
		chk(fsr_q, 64'h80000145, "fsr after load");
		send(rq(FSIO_K_STFSR, 2'b00, 5'h0, 64'h0, 7'h0), FSIO_T_NONE);
		chk(rsp_q.data, 64'h80000145, "stored fsr");
		send(rq(FSIO_K_FPOP, 2'b10, 5'h0, 64'h0, 7'h04), FSIO_T_NONE);
		chk(fsr_q[16:0], 64'h161, "inexact accrued");
		send(rq(FSIO_K_FPOP, 2'b10, 5'h0, 64'h0, 7'h06), FSIO_T_NONE);
		chk(fsr_q[16:0], 64'h1e5, "tiny inexact");
		send(rq(FSIO_K_FPOP, 2'b10, 5'h0, 64'h0, 7'h12), FSIO_T_NONE);
		chk(fsr_q[16:0], 64'h1e0, "tiny exact");
		send(rq(FSIO_K_LDFSR, 2'b00, 5'h0, 64'h800000, 7'h0), FSIO_T_NONE);
		send(rq(FSIO_K_FPOP, 2'b10, 5'h0, 64'h0, 7'h04), FSIO_T_FP_IEEE);
		chk(fsr_q[16:0], 64'h4001, "trapped inexact");
		$display("test fsr done");
	endtask
	task t_unimpl;
		send(rq(FSIO_K_OTHER, 2'b00, 5'h0, 64'h0, 7'h0), FSIO_T_ILLEGAL);
		send(rq(FSIO_K_OTHER, 2'b10, 5'h0, 64'h0, 7'h0), FSIO_T_NONE);
		send(rq(fsio_kind_t'(3'h4), 2'b10, 5'h0, 64'h0, 7'h0), FSIO_T_ILLEGAL);
		send(rq(FSIO_K_FPOP, 2'b00, 5'h0, 64'h0, 7'h0), FSIO_T_FP_MISC);
		chk(fsr_q[16:14], 64'h3, "missing op code");
		send(rq(FSIO_K_FPOP, 2'b10, 5'h0, 64'h0, 7'h01), FSIO_T_FP_MISC);
		chk(fsr_q[16:14], 64'h2, "incomplete op code");
		$display("test unimpl done");
	endtask
	task t_asr;
		logic [31:0] def;
		def = 32'h03f8007d;
		for (int n = 0; n < 32; n++) begin
			send(rq(FSIO_K_RDASR, 2'b01, 5'(n), 64'h0, 7'h0),
				(n < 28 && !def[n]) ? FSIO_T_ILLEGAL : FSIO_T_NONE);
		end
		send(rq(FSIO_K_WRASR, 2'b01, 5'h1d, 64'h5a5a, 7'h0), FSIO_T_NONE);
		send(rq(FSIO_K_RDASR, 2'b01, 5'h1d, 64'h0, 7'h0), FSIO_T_NONE);
		chk(rsp_q.data, 64'h5a5a, "asr readback");
		send(rq(FSIO_K_RDASR, 2'b00, 5'h1f, 64'h0, 7'h0), FSIO_T_PRIV);
		send(rq(FSIO_K_WRASR, 2'b01, 5'h01, 64'h0, 7'h0), FSIO_T_ILLEGAL);
		send(rq(FSIO_K_READ_PRIVILEGED_REGISTER_INSTR, 2'b01, 5'h0f, 64'h0, 7'h0), FSIO_T_ILLEGAL);
		send(rq(FSIO_K_READ_PRIVILEGED_REGISTER_INSTR, 2'b01, 5'h0e, 64'h0, 7'h0), FSIO_T_NONE);
		$display("test asr done");
	endtask
	task t_rf;
		rf_cyc(1'b1, 5'h10, 5'h0, 64'ha1, 3'h2);
		chk(rf_rdata_q, 64'h0, "r0 read");
		rf_cyc(1'b0, 5'h0, 5'h10, 64'h0, 3'h2);
		chk(rf_rdata_q, 64'ha1, "local readback");
		rf_cyc(1'b1, 5'h18, 5'h0, 64'hb2, 3'h3);
		rf_cyc(1'b0, 5'h0, 5'h08, 64'h0, 3'h2);
		chk(rf_rdata_q, 64'hb2, "window overlap");
		rf_cyc(1'b1, 5'h18, 5'h0, 64'hc3, 3'h0);
		rf_cyc(1'b1, 5'h0, 5'h08, 64'hd4, 3'h7);
		chk(rf_rdata_q, 64'hc3, "window wrap");
		rf_cyc(1'b0, 5'h0, 5'h0, 64'h0, 3'h7);
		chk(rf_rdata_q, 64'h0, "r0 write ignored");
		rf_cyc(1'b1, 5'h01, 5'h0, 64'he5, 3'h7);
		@(posedge clock);
		gl <= 2'h2;
		rf_cyc(1'b1, 5'h01, 5'h0, 64'hf6, 3'h7);
		@(posedge clock);
		gl <= 2'h3;
		rf_cyc(1'b0, 5'h0, 5'h01, 64'h0, 3'h7);
		chk(rf_rdata_q, 64'hf6, "global level clamp");
		@(posedge clock);
		gl <= 2'h0;
		rf_cyc(1'b0, 5'h0, 5'h01, 64'h0, 3'h7);
		chk(rf_rdata_q, 64'he5, "global set zero");
		$display("test rf done");
	endtask
	task t_ce;
		logic [63:0] held;
		held = fsr_q;
		@(posedge clock);
		ce <= 1'b0;
		req <= rq(FSIO_K_FPOP, 2'b00, 5'h0, 64'h0, 7'h0);
		repeat (2) @(posedge clock);
		#1;
		chk(rsp_valid_q, 64'h0, "answer while frozen");
		chk(fsr_q, held, "fsr while frozen");
		@(posedge clock);
		ce <= 1'b1;
		@(posedge clock);
		req.valid <= 1'b0;
		#1;
		chk(rsp_valid_q, 64'h1, "answer after thaw");
		chk(fsr_q[16:14], 64'h3, "missing op after thaw");
		$display("test ce done");
	endtask
	initial begin
		err_total = 0;
		n_checks = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		req = '0;
		rf_we = 1'b0;
		rf_widx = 5'h0;
		rf_ridx = 5'h0;
		rf_wdata = 64'h0;
		cwp = 3'h0;
		gl = 2'h0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		t_fsr;
		t_unimpl;
		t_asr;
		t_rf;
		t_ce;
		print_verdict;
	end
	// tests need about 150 cycles; generous margin
	initial begin
		repeat (2000) @(posedge clock);
		err_total++;
		print_verdict;
	end
endmodule
